/* rtl/sasr_pkg.sv */
// Constants, types and helper functions of the angle sensor readout core
package sasr_pkg;
  // Memory map, word addresses
  localparam logic [7:0] ADDR_ANGLE    = 8'h00;
  localparam logic [7:0] ADDR_RAW_SIN  = 8'h01;
  localparam logic [7:0] ADDR_RAW_COS  = 8'h02;
  localparam logic [7:0] ADDR_TREND    = 8'h03;
  localparam logic [7:0] ADDR_SENSE    = 8'h40;
  localparam logic [7:0] ADDR_ZERO     = 8'h41;
  localparam logic [7:0] ADDR_SMOOTH   = 8'h42;
  localparam logic [7:0] ADDR_HYST     = 8'h43;
  localparam logic [7:0] ADDR_LOT_YEAR = 8'h80;
  localparam logic [7:0] ADDR_LOT_WEEK = 8'h81;
  localparam logic [7:0] ADDR_LOT_INT  = 8'h82;
  // Field positions
  localparam int SENSE_BIT  = 0;
  localparam int ZERO_MSB   = 13;
  // Reset values
  localparam logic        RST_SENSE  = 1'h0;
  localparam logic [13:0] RST_ZERO   = 14'h0000;
  localparam logic [7:0]  RST_SMOOTH = 8'h01;
  localparam logic [7:0]  RST_HYST   = 8'h19;
  // Value limits
  localparam logic [13:0] ZERO_MAX   = 14'h0E10;
  localparam logic [7:0]  SMOOTH_MIN = 8'h01;
  // Angle scale: tenths of a degree, four fraction bits inside
  localparam logic [11:0] TURN       = 12'hE10;
  localparam logic [17:0] TURN_FINE  = 18'h0E100;
  localparam logic [17:0] HALF_FINE  = 18'h07080;
  localparam logic [12:0] ADC_MID    = 13'h0800;
  // Lot code, values arbitrary
  localparam logic [15:0] LOT_YEAR_CODE = 16'h3030;
  localparam logic [15:0] LOT_WEEK_CODE = 16'h3031;
  localparam logic [15:0] LOT_INT_CODE  = 16'h4141;
  // Timing
  localparam int unsigned CLK_HZ          = 250000000;
  localparam int unsigned SAMPLE_RATE_HZ  = 12500;
  localparam int unsigned SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int unsigned NV_STORE_MS     = 20;
  localparam int unsigned NV_STORE_CYCLES = CLK_HZ / 1000 * NV_STORE_MS;
  localparam int unsigned INTER_COMMAND_GAP_US = 3;
  localparam int unsigned FETCH_WAIT_TIME_US   = 10;
  localparam int unsigned FETCH_WAIT_CYCLES    = CLK_HZ / 1000000 * FETCH_WAIT_TIME_US;
  localparam logic [3:0]  CORDIC_LAST     = 4'hB;
  localparam logic [4:0]  DIV_LAST        = 5'h10;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
  } sasr_cmd_t;

  typedef struct packed {
    logic        sense;
    logic [13:0] zero;
    logic [7:0]  smooth;
    logic [7:0]  hyst;
  } sasr_param_t;

  typedef enum logic [2:0] {S_WAIT, S_CONV, S_ROT, S_POST, S_DIV, S_APPLY, S_DONE} sasr_state_t;

  // Arc tangent of 2^-i in sixteenths of a tenth degree
  function automatic logic signed [18:0] sasr_atan(input logic [3:0] i);
    case (i)
      4'h0:    sasr_atan = 19'sh01C20;
      4'h1:    sasr_atan = 19'sh0109A;
      4'h2:    sasr_atan = 19'sh008C6;
      4'h3:    sasr_atan = 19'sh00474;
      4'h4:    sasr_atan = 19'sh0023C;
      4'h5:    sasr_atan = 19'sh0011E;
      4'h6:    sasr_atan = 19'sh0008F;
      4'h7:    sasr_atan = 19'sh00048;
      4'h8:    sasr_atan = 19'sh00024;
      4'h9:    sasr_atan = 19'sh00012;
      4'hA:    sasr_atan = 19'sh00009;
      default: sasr_atan = 19'sh00004;
    endcase
  endfunction : sasr_atan

  // Shortest signed distance around a circle of size full
  function automatic logic signed [18:0] sasr_wrap(input logic signed [18:0] d,
                                                    input logic signed [18:0] full);
    logic signed [18:0] half;
    half = full >>> 1;
    if (d > half) sasr_wrap = d - full;
    else if (d < -half) sasr_wrap = d + full;
    else sasr_wrap = d;
  endfunction : sasr_wrap
endpackage : sasr_pkg

/* rtl/sasr_core.sv */
// Digital core of the angle sensor: measurement, smoothing, direction and serial memory access
// Contract
// R1: Sine and cosine arrive as 12-bit converter samples; angle is computed from them.
// R2: A new measurement is started at about 12500 samples per second.
// R3: Filtered angle equals measured over m plus (m-1)/m of previous filtered.
// R4: Filter constant one bypasses smoothing; one is the reset default.
// R5: Bit 0 of counting sense picks whether angle rises counterclockwise or clockwise.
// R6: The 14-bit zero reference is subtracted; angle wraps from 3600 to 0.
// R7: Direction flag changes only after movement beyond hysteresis; default 25 tenths.
// R8: Direction flag reads one when angle increases, zero when decreasing.
// R9: Serial mode 0: sample on rising clock, shift on falling, device is slave.
// R10: Select is active low; bits and bytes travel most significant first.
// R11: Master keeps the serial rate at or below two megabits per second.
// R12: Each falling select edge restarts the serial interface state.
// R13: Command is an address byte, then a byte whose bit 0 means write.
// R14: Access is two command bytes then two value bytes, read or written.
// R15: Repeated zero byte pairs return the current angle in every pair.
// R16: Master waits at least 3 us between the two command bytes.
// R17: Master waits at least 10 us after the command before data bytes.
// R18: Master allows 20 ms after a parameter write before the next transaction.
// R19: Unused parameter bits read as zero; master writes zeros there.
// R20: Location zero holds the processed angle, tenths of degree, 0 to 3600.
// R21: Raw sine and cosine samples are readable, read only.
// R22: Read only lot code sits at 0x80, 0x81 and 0x82.
// R23: User parameters persist in nonvolatile storage and apply at power up; the core reloads fixed reset defaults instead.
// R24: Serial output is driven only while select is low.
// R25: Out of range parameter writes are ignored; the old value stays.
module sasr_core #(
  parameter int unsigned SAMPLE_CYCLES   = sasr_pkg::SAMPLE_CYCLES,
  parameter int unsigned NV_STORE_CYCLES = sasr_pkg::NV_STORE_CYCLES
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Serial link
  input  wire logic        spi_sclk,
  input  wire logic        spi_ss_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso_o,
  output logic             spi_miso_oe,
  // Converter
  output logic             adc_start,
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_sine,
  input  wire logic [11:0] adc_cosine,
  // Status
  output logic             nv_busy
);
  localparam int SW = $clog2(SAMPLE_CYCLES);
  localparam int NW = $clog2(NV_STORE_CYCLES + 1);

  if (SAMPLE_CYCLES < 64 || NV_STORE_CYCLES < 1) begin : g_chk
    $error("sample period too short for the pipeline");
  end

  // Link clock domain
  logic                lk_rst_n;
  logic [3:0]          lk_bit_r;
  logic                lk_data_ph_r;
  logic [14:0]         lk_shift_r;
  logic [15:0]         lk_word;
  sasr_pkg::sasr_cmd_t lk_cmd_r;
  logic                lk_cmd_tgl_r;
  logic [15:0]         lk_wdata_r;
  logic                lk_wr_tgl_r;

  // Select high clears the frame state, so each falling edge starts fresh
  assign lk_rst_n = arst_n & ~spi_ss_n; // see R12
  assign lk_word  = {lk_shift_r, spi_mosi};

  always_ff @(posedge spi_sclk or negedge lk_rst_n) begin // see R9
    if (!lk_rst_n) begin
      lk_bit_r     <= 4'h0;
      lk_data_ph_r <= 1'b0;
      lk_shift_r   <= 15'h0000;
    end else begin
      lk_shift_r <= lk_word[14:0]; // see R10
      lk_bit_r   <= lk_bit_r + 4'h1;
      if (lk_bit_r == 4'hF) begin
        lk_data_ph_r <= ~lk_data_ph_r; // see R14
      end
    end
  end

  // Kept across frames: a reset here would look like a toggle to the core
  always_ff @(posedge spi_sclk or negedge arst_n) begin
    if (!arst_n) begin
      lk_cmd_r     <= '0;
      lk_cmd_tgl_r <= 1'b0;
      lk_wdata_r   <= 16'h0000;
      lk_wr_tgl_r  <= 1'b0;
    end else if (lk_bit_r == 4'hF) begin
      if (!lk_data_ph_r) begin
        lk_cmd_r.addr <= lk_word[15:8]; // see R13
        lk_cmd_r.wr   <= lk_word[0];
        lk_cmd_tgl_r  <= ~lk_cmd_tgl_r;
      end else if (lk_cmd_r.wr) begin
        lk_wdata_r  <= lk_word;
        lk_wr_tgl_r <= ~lk_wr_tgl_r;
      end
    end
  end

  // Synchronisers into the system clock
  logic [1:0] ss_sync_r;
  logic [2:0] sclk_sync_r;
  logic [2:0] ctg_sync_r;
  logic [2:0] wtg_sync_r;
  logic       sclk_fall;
  logic       cmd_evt;
  logic       wr_evt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ss_sync_r   <= 2'h3;
      sclk_sync_r <= 3'h0;
      ctg_sync_r  <= 3'h0;
      wtg_sync_r  <= 3'h0;
    end else begin
      ss_sync_r   <= {ss_sync_r[0], spi_ss_n};
      sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
      ctg_sync_r  <= {ctg_sync_r[1:0], lk_cmd_tgl_r};
      wtg_sync_r  <= {wtg_sync_r[1:0], lk_wr_tgl_r};
    end
  end

  assign sclk_fall = sclk_sync_r[2] & ~sclk_sync_r[1];
  assign cmd_evt   = ctg_sync_r[2] ^ ctg_sync_r[1];
  assign wr_evt    = wtg_sync_r[2] ^ wtg_sync_r[1];

  // Parameters, measurement results and fetch
  sasr_pkg::sasr_param_t prm_r;
  sasr_pkg::sasr_cmd_t   cmd_r;
  logic [15:0]           rd_data_r;
  logic [15:0]           rd_word;
  logic [11:0]           angle_r;
  logic [11:0]           raw_sin_r;
  logic [11:0]           raw_cos_r;
  logic                  trend_r;
  logic [NW-1:0]         nv_cnt_r;
  logic                  wr_ok;
  logic                  tx_ph_r;

  // Unused upper bits read as zero
  always_comb begin // see R19
    rd_word = 16'h0000;
    if (cmd_r.addr == sasr_pkg::ADDR_ANGLE) rd_word = {4'h0, angle_r}; // see R20
    else if (cmd_r.addr == sasr_pkg::ADDR_RAW_SIN) rd_word = {4'h0, raw_sin_r}; // see R21
    else if (cmd_r.addr == sasr_pkg::ADDR_RAW_COS) rd_word = {4'h0, raw_cos_r};
    else if (cmd_r.addr == sasr_pkg::ADDR_TREND) rd_word = {15'h0000, trend_r}; // see R8
    else if (cmd_r.addr == sasr_pkg::ADDR_SENSE) rd_word = {15'h0000, prm_r.sense};
    else if (cmd_r.addr == sasr_pkg::ADDR_ZERO) rd_word = {2'h0, prm_r.zero};
    else if (cmd_r.addr == sasr_pkg::ADDR_SMOOTH) rd_word = {8'h00, prm_r.smooth};
    else if (cmd_r.addr == sasr_pkg::ADDR_HYST) rd_word = {8'h00, prm_r.hyst};
    else if (cmd_r.addr == sasr_pkg::ADDR_LOT_YEAR) rd_word = sasr_pkg::LOT_YEAR_CODE; // see R22
    else if (cmd_r.addr == sasr_pkg::ADDR_LOT_WEEK) rd_word = sasr_pkg::LOT_WEEK_CODE;
    else if (cmd_r.addr == sasr_pkg::ADDR_LOT_INT) rd_word = sasr_pkg::LOT_INT_CODE;
  end

  // Command fetch; the address stays stable because the master waits before data
  always_ff @(posedge clk_sys or negedge arst_n) begin // see R17
    if (!arst_n) begin
      cmd_r <= '0;
    end else if (cmd_evt) begin
      cmd_r <= lk_cmd_r;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 16'h0000;
    end else if (!tx_ph_r) begin // Frozen while shifted out, so a new sample cannot tear the word
      rd_data_r <= rd_word;
    end
  end

  // Range check per parameter
  always_comb begin // see R25
    wr_ok = 1'b0;
    if (cmd_r.addr == sasr_pkg::ADDR_SENSE) wr_ok = (lk_wdata_r[15:1] == 15'h0000);
    else if (cmd_r.addr == sasr_pkg::ADDR_ZERO) wr_ok = (lk_wdata_r <= {2'h0, sasr_pkg::ZERO_MAX});
    else if (cmd_r.addr == sasr_pkg::ADDR_SMOOTH) wr_ok = (lk_wdata_r[15:8] == 8'h00) &&
                                                       (lk_wdata_r[7:0] >= sasr_pkg::SMOOTH_MIN);
    else if (cmd_r.addr == sasr_pkg::ADDR_HYST) wr_ok = (lk_wdata_r[15:8] == 8'h00);
  end

  // Power-on reset alone reloads the fixed reset defaults; a select edge never does
  always_ff @(posedge clk_sys or negedge arst_n) begin // see R23
    if (!arst_n) begin
      prm_r.sense  <= sasr_pkg::RST_SENSE;
      prm_r.zero   <= sasr_pkg::RST_ZERO;
      prm_r.smooth <= sasr_pkg::RST_SMOOTH; // see R4
      prm_r.hyst   <= sasr_pkg::RST_HYST; // see R7
    end else if (wr_evt && cmd_r.wr && wr_ok && !nv_busy) begin
      if (cmd_r.addr == sasr_pkg::ADDR_SENSE) prm_r.sense <= lk_wdata_r[sasr_pkg::SENSE_BIT];
      else if (cmd_r.addr == sasr_pkg::ADDR_ZERO) prm_r.zero <= lk_wdata_r[sasr_pkg::ZERO_MSB:0];
      else if (cmd_r.addr == sasr_pkg::ADDR_SMOOTH) prm_r.smooth <= lk_wdata_r[7:0];
      else prm_r.hyst <= lk_wdata_r[7:0];
    end
  end

  // Store timer; writes during a store are dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin // see R18
    if (!arst_n) begin
      nv_cnt_r <= '0;
      nv_busy  <= 1'b0;
    end else if (wr_evt && cmd_r.wr && wr_ok && !nv_busy) begin
      nv_cnt_r <= NW'(NV_STORE_CYCLES - 1);
      nv_busy  <= 1'b1;
    end else if (nv_cnt_r != '0) begin
      nv_cnt_r <= nv_cnt_r - 1'b1;
    end else begin
      nv_busy <= 1'b0;
    end
  end

  // Transmit side: shifts on synchronised falling edges so fetched data can follow
  logic [3:0]  tx_bit_r;
  logic [15:0] ang_snap_r;
  logic [15:0] tx_word;

  assign tx_word = tx_ph_r ? rd_data_r : ang_snap_r; // see R15

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_bit_r    <= 4'h0;
      tx_ph_r     <= 1'b0;
      ang_snap_r  <= 16'h0000;
      spi_miso_o  <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (ss_sync_r[1]) begin
      tx_bit_r    <= 4'h0; // see R12
      tx_ph_r     <= 1'b0;
      ang_snap_r  <= {4'h0, angle_r};
      spi_miso_o  <= 1'b0;
      spi_miso_oe <= 1'b0; // see R24
    end else begin
      spi_miso_oe <= 1'b1;
      spi_miso_o  <= tx_word[~tx_bit_r]; // see R10
      if (sclk_fall) begin // see R9
        tx_bit_r <= tx_bit_r + 4'h1;
        if (tx_bit_r == 4'hF) begin
          tx_ph_r <= ~tx_ph_r;
          if (tx_ph_r) ang_snap_r <= {4'h0, angle_r};
        end
      end
    end
  end

  // Measurement pipeline
  sasr_pkg::sasr_state_t st_r;
  logic [SW-1:0]         tmr_r;
  logic [3:0]            it_r;
  logic [4:0]            dv_r;
  logic signed [15:0]    cx_r;
  logic signed [15:0]    cy_r;
  logic signed [18:0]    cz_r;
  logic signed [15:0]    x0;
  logic signed [15:0]    y0;
  logic [17:0]           zfine;
  logic [11:0]           ang_s;
  logic [12:0]           ang_o;
  logic [15:0]           theta_r;
  logic [15:0]           filt_r;
  logic signed [18:0]    fd;
  logic                  neg_r;
  logic [16:0]           quo_r;
  logic [8:0]            rem_r;
  logic [8:0]            rem_sh;
  logic signed [18:0]    fsum;
  logic [11:0]           ref_r;
  logic signed [18:0]    td;

  assign x0 = 16'(signed'({1'b0, adc_cosine}) - signed'(sasr_pkg::ADC_MID)); // see R1
  assign y0 = 16'(signed'({1'b0, adc_sine}) - signed'(sasr_pkg::ADC_MID));
  assign zfine = cz_r < 0 ? 18'(cz_r + signed'({1'b0, sasr_pkg::TURN_FINE})) : 18'(cz_r);
  assign ang_s = (prm_r.sense && zfine[15:4] != 12'h000) ? sasr_pkg::TURN - zfine[15:4]
                                                          : zfine[15:4]; // see R5
  assign ang_o = {1'b0, ang_s} - 13'(prm_r.zero);
  assign fd = sasr_pkg::sasr_wrap(19'({3'h0, theta_r}) - 19'({3'h0, filt_r}),
                                  19'(sasr_pkg::TURN_FINE));
  assign rem_sh = {rem_r[7:0], quo_r[16]};
  assign fsum = 19'({3'h0, filt_r}) + (neg_r ? -19'({2'h0, quo_r}) : 19'({2'h0, quo_r}));
  assign td = sasr_pkg::sasr_wrap(19'({7'h00, filt_r[15:4]}) - 19'({7'h00, ref_r}),
                                  19'({7'h00, sasr_pkg::TURN}));

  // Sample period timer
  always_ff @(posedge clk_sys or negedge arst_n) begin // see R2
    if (!arst_n) begin
      tmr_r     <= '0;
      adc_start <= 1'b0;
    end else begin
      adc_start <= (tmr_r == '0) && (st_r == sasr_pkg::S_WAIT);
      tmr_r     <= (tmr_r == '0) ? SW'(SAMPLE_CYCLES - 1) : tmr_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r      <= sasr_pkg::S_WAIT;
      it_r      <= 4'h0;
      dv_r      <= 5'h00;
      cx_r      <= 16'sh0000;
      cy_r      <= 16'sh0000;
      cz_r      <= 19'sh00000;
      raw_sin_r <= 12'h000;
      raw_cos_r <= 12'h000;
      theta_r   <= 16'h0000;
      filt_r    <= 16'h0000;
      neg_r     <= 1'b0;
      quo_r     <= 17'h00000;
      rem_r     <= 9'h000;
      angle_r   <= 12'h000;
      ref_r     <= 12'h000;
      trend_r   <= 1'b0;
    end else begin
      case (st_r)
        sasr_pkg::S_WAIT: begin
          if (adc_start) st_r <= sasr_pkg::S_CONV;
        end
        sasr_pkg::S_CONV: begin
          if (adc_done) begin // see R1
            raw_sin_r <= adc_sine; // see R21
            raw_cos_r <= adc_cosine;
            // Fold into the right half plane so the rotation converges
            cx_r <= x0 < 0 ? -x0 : x0;
            cy_r <= x0 < 0 ? -y0 : y0;
            cz_r <= x0 < 0 ? 19'({1'b0, sasr_pkg::HALF_FINE}) : 19'sh00000;
            it_r <= 4'h0;
            st_r <= sasr_pkg::S_ROT;
          end
        end
        sasr_pkg::S_ROT: begin
          if (cy_r >= 0) begin
            cx_r <= cx_r + (cy_r >>> it_r);
            cy_r <= cy_r - (cx_r >>> it_r);
            cz_r <= cz_r + sasr_pkg::sasr_atan(it_r);
          end else begin
            cx_r <= cx_r - (cy_r >>> it_r);
            cy_r <= cy_r + (cx_r >>> it_r);
            cz_r <= cz_r - sasr_pkg::sasr_atan(it_r);
          end
          it_r <= it_r + 4'h1;
          if (it_r == sasr_pkg::CORDIC_LAST) st_r <= sasr_pkg::S_POST;
        end
        sasr_pkg::S_POST: begin
          // Offset subtraction wraps through 3600
          theta_r <= ang_o[12] ? {ang_o[11:0] + sasr_pkg::TURN, 4'h0} : {ang_o[11:0], 4'h0}; // see R6
          st_r    <= sasr_pkg::S_DIV;
          dv_r    <= 5'h00;
          rem_r   <= 9'h000;
        end
        sasr_pkg::S_DIV: begin
          if (prm_r.smooth == sasr_pkg::RST_SMOOTH) begin
            filt_r <= theta_r; // see R4
            st_r   <= sasr_pkg::S_DONE;
          end else if (dv_r == 5'h00 && rem_r == 9'h000 && !neg_r && quo_r == 17'h00000) begin
            // Load magnitude of the shortest step toward the new sample
            neg_r <= fd < 0;
            quo_r <= fd < 0 ? 17'(-fd) : 17'(fd);
            rem_r <= 9'h100;
          end else begin
            // Restoring division by m, one quotient bit per cycle
            if (dv_r == 5'h00) rem_r <= 9'h000;
            if (dv_r != 5'h00 && rem_sh >= {1'b0, prm_r.smooth}) begin // see R3
              rem_r <= rem_sh - {1'b0, prm_r.smooth};
              quo_r <= {quo_r[15:0], 1'b1};
            end else if (dv_r != 5'h00) begin
              rem_r <= rem_sh;
              quo_r <= {quo_r[15:0], 1'b0};
            end
            dv_r <= dv_r + 5'h01;
            if (dv_r == sasr_pkg::DIV_LAST + 5'h01) st_r <= sasr_pkg::S_APPLY;
          end
        end
        sasr_pkg::S_APPLY: begin
          // New value is old plus (sample - old) / m, kept on the circle
          if (fsum < 0) filt_r <= 16'(fsum + 19'({1'b0, sasr_pkg::TURN_FINE})); // see R3
          else if (fsum >= 19'({1'b0, sasr_pkg::TURN_FINE})) filt_r <= 16'(fsum - 19'({1'b0, sasr_pkg::TURN_FINE}));
          else filt_r <= 16'(fsum);
          neg_r <= 1'b0;
          quo_r <= 17'h00000;
          rem_r <= 9'h000;
          dv_r  <= 5'h00;
          st_r  <= sasr_pkg::S_DONE;
        end
        default: begin
          angle_r <= filt_r[15:4]; // see R20
          // Hysteresis keeps the flag from chattering at low speed
          if (td > signed'(19'({11'h000, prm_r.hyst}))) begin // see R7
            trend_r <= 1'b1; // see R8
            ref_r   <= filt_r[15:4];
          end else if (-td > signed'(19'({11'h000, prm_r.hyst}))) begin
            trend_r <= 1'b0;
            ref_r   <= filt_r[15:4];
          end
          st_r <= sasr_pkg::S_WAIT;
        end
      endcase
    end
  end
endmodule : sasr_core

/* test/sasr_core_asserts.sv */
// Port-level assertions for the angle sensor core
module sasr_core_asserts #(
  parameter int unsigned SAMPLE_CYCLES   = 200,
  parameter int unsigned NV_STORE_CYCLES = 50
) (
  // System
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Serial link
  input wire logic        spi_sclk,
  input wire logic        spi_ss_n,
  input wire logic        spi_mosi,
  input wire logic        spi_miso_o,
  input wire logic        spi_miso_oe,
  // Converter
  input wire logic        adc_start,
  input wire logic        adc_done,
  input wire logic [11:0] adc_sine,
  input wire logic [11:0] adc_cosine,
  // Status
  input wire logic        nv_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned gap_r;
  int unsigned busy_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Cycles since last conversion start, and length of the current store
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_r  <= 32'h0;
      busy_r <= 32'h0;
    end else begin
      gap_r  <= adc_start ? 32'h0 : gap_r + 32'h1;
      busy_r <= nv_busy ? busy_r + 32'h1 : 32'h0;
    end
  end
  property p_oe_off; spi_ss_n [*8] |-> !spi_miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("serial output driven while deselected");
  property p_oe_on; !spi_ss_n [*8] |-> spi_miso_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial output not driven while selected");
  property p_ss_start; $fell(spi_ss_n) |-> ##[2:6] spi_miso_oe; endproperty
  a_ss_start: assert property (p_ss_start) else $error("frame start not answered in time");
  property p_miso_hold; (spi_sclk && !spi_ss_n) [*8] |-> $stable(spi_miso_o); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("serial output moved while clock high");
  property p_start_gap; adc_start |=> !adc_start [*8]; endproperty
  a_start_gap: assert property (p_start_gap) else $error("conversion starts too close");
  property p_start_period; gap_r <= SAMPLE_CYCLES + 64; endproperty
  a_start_period: assert property (p_start_period) else $error("conversion start overdue");
  property p_busy_hold; $rose(nv_busy) |-> nv_busy [*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("store busy dropped early");
  property p_busy_len; busy_r <= NV_STORE_CYCLES + 2; endproperty
  a_busy_len: assert property (p_busy_len) else $error("store busy too long");
  property p_busy_src; $rose(nv_busy) |-> spi_miso_oe; endproperty
  a_busy_src: assert property (p_busy_src) else $error("store started outside a frame");
endmodule : sasr_core_asserts

/* test/sasr_spi_master.sv */
// Behavioural serial master facing the angle sensor core
module sasr_spi_master (
  // Serial link
  output logic      spi_sclk,
  output logic      spi_ss_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick;
  // Own 12 ns time base; the serial clock only moves inside frames
  initial begin
    tick     = 1'b0;
    spi_sclk = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
    #1.7;
    forever #6 tick = ~tick;
  end
  task automatic wait_t(input int n);
    repeat (n) @(posedge tick);
  endtask : wait_t
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      wait_t(21);
      spi_sclk <= 1'b1;
      rx[i] = spi_miso;
      wait_t(21);
      spi_sclk <= 1'b0;
    end
  endtask : xfer_byte
  task automatic access(input logic [7:0] addr, input logic wr, input logic [15:0] wdata,
                        output logic [15:0] cmd_rx, output logic [15:0] rx);
    spi_ss_n <= 1'b0;
    wait_t(21);
    xfer_byte(addr, cmd_rx[15:8]);
    wait_t(250);
    xfer_byte({7'h00, wr}, cmd_rx[7:0]);
    wait_t(834);
    xfer_byte(wdata[15:8], rx[15:8]);
    xfer_byte(wdata[7:0], rx[7:0]);
    wait_t(21);
    spi_ss_n <= 1'b1;
    // Released data line must not keep its last level
    spi_mosi <= ~spi_mosi;
    wait_t(21);
  endtask : access
endmodule : sasr_spi_master

/* test/test_sasr_core.sv */
// Self-checking bench for the angle sensor core
module test_sasr_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SAMPLE_N = 200;
  localparam int unsigned NV_N     = 50;
  logic        clk_sys    = 1'b0;
  logic        arst_n     = 1'b0;
  logic        adc_done   = 1'b0;
  logic [11:0] adc_sine   = 12'h9F4;
  logic [11:0] adc_cosine = 12'h800;
  logic [9:0]  conv_r     = 10'h000;
  logic        busy_seen  = 1'b0;
  logic [15:0] cmd_rx;
  logic [15:0] rx;
  wire logic   spi_sclk, spi_ss_n, spi_mosi, spi_miso_o, spi_miso_oe, adc_start, nv_busy;
  wire         spi_miso = spi_miso_oe ? spi_miso_o : 1'bz;
  int          mismatches = 0;
  int          checks     = 0;
  int          cycles     = 0;
  sasr_core #(.SAMPLE_CYCLES(SAMPLE_N), .NV_STORE_CYCLES(NV_N)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .adc_start(adc_start), .adc_done(adc_done),
    .adc_sine(adc_sine), .adc_cosine(adc_cosine), .nv_busy(nv_busy));
  sasr_spi_master m_spi (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // Converter answers eleven cycles after each start
  always @(posedge clk_sys) begin
    conv_r   <= {conv_r[8:0], adc_start};
    adc_done <= conv_r[9];
    if (nv_busy === 1'b1) busy_seen <= 1'b1;
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp, input int tol);
    int d;
    checks++;
    d = (int'(seen) + 3600 - int'(exp)) % 3600;
    if (d > 1800) d = 3600 - d;
    if (tol == 0 ? seen !== exp : (^seen === 1'bx || d > tol)) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] ang);
    m_spi.access(a, 1'b0, 16'h0000, cmd_rx, rx);
    check("angle snapshot", cmd_rx, ang, 2);
    check("read value", rx, exp, 0);
  endtask : rd_reg
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic taken);
    busy_seen = 1'b0;
    m_spi.access(a, 1'b1, d, cmd_rx, rx);
    repeat (NV_N) @(posedge clk_sys);
    check("store started", {15'h0000, busy_seen}, {15'h0000, taken}, 0);
  endtask : wr_reg
  task automatic set_raw(input logic [11:0] s, input logic [11:0] c);
    @(posedge clk_sys);
    adc_sine   <= s;
    adc_cosine <= c;
    repeat (3 * SAMPLE_N) @(posedge clk_sys);
  endtask : set_raw
  task automatic t_defaults();
    rd_reg(sasr_pkg::ADDR_SMOOTH, 16'h0001, 16'h0384);
    rd_reg(sasr_pkg::ADDR_HYST, 16'h0019, 16'h0384);
    rd_reg(sasr_pkg::ADDR_RAW_SIN, 16'h09F4, 16'h0384);
    rd_reg(sasr_pkg::ADDR_LOT_YEAR, sasr_pkg::LOT_YEAR_CODE, 16'h0384);
  endtask : t_defaults
  task automatic t_continuous();
    rd_reg(sasr_pkg::ADDR_ANGLE, 16'h0384, 16'h0384);
  endtask : t_continuous
  task automatic t_zero();
    wr_reg(sasr_pkg::ADDR_ZERO, 16'h0384, 1'b1);
    wr_reg(sasr_pkg::ADDR_ZERO, 16'h0E11, 1'b0);
    rd_reg(sasr_pkg::ADDR_ZERO, 16'h0384, 16'h0000);
  endtask : t_zero
  task automatic t_trend();
    rd_reg(sasr_pkg::ADDR_TREND, 16'h0000, 16'h0000);
    set_raw(12'h962, 12'h69E);
    rd_reg(sasr_pkg::ADDR_TREND, 16'h0001, 16'h01C2);
  endtask : t_trend
  task automatic t_sense();
    wr_reg(sasr_pkg::ADDR_SENSE, 16'h0001, 1'b1);
    rd_reg(sasr_pkg::ADDR_SENSE, 16'h0001, 16'h0546);
  endtask : t_sense
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Let the first samples settle before any frame
    repeat (3 * SAMPLE_N) @(posedge clk_sys);
    t_defaults();
    t_continuous();
    t_zero();
    t_trend();
    t_sense();
    complete_run();
  end
endmodule : test_sasr_core
bind sasr_core sasr_core_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .NV_STORE_CYCLES(NV_STORE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
  .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .adc_start(adc_start), .adc_done(adc_done),
  .adc_sine(adc_sine), .adc_cosine(adc_cosine), .nv_busy(nv_busy));
